/* File: irot_top.sv */
`timescale 1ns/1ps
// Function
// - One routing bit per source, data ready at bit 7, all reset 0.
// - Routing bit 0 sends source to pin B, 1 sends it to pin A.
// - Each pin carries the OR of enabled sources routed to it.
// - Several sources may assert one pin together; none masks another.
// - Pressure trim is signed byte, 4 Pa per count, added to pressure.
// - Temperature trim is signed byte, 0.0625 C per count.
// - Altitude offset is signed byte in whole meters, shifts altitude.
// - Pressure trim is read/write 8 bits, resets to zero.
// - Temperature and altitude trims are read/write 8 bits, reset zero.
// - Only enabled sources reach either pin.
// - Each pin has a polarity select: 0 active low, 1 active high.
module irot_top
  import irot_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic [IROT_NUM_SRC-1:0] SRC_EVENT,
  output logic IRQ_PIN_A_O,
  output logic IRQ_PIN_A_OE,
  output logic IRQ_PIN_B_O,
  output logic IRQ_PIN_B_OE,
  input wire logic MEAS_VALID,
  input wire logic [IROT_PRESSURE_W-1:0] MEAS_PRESSURE,
  input wire logic [IROT_ALT_W-1:0] MEAS_ALTITUDE,
  input wire logic [IROT_TEMP_W-1:0] MEAS_TEMP,
  output logic [IROT_PRESSURE_W-1:0] OUT_PRESSURE,
  output logic [IROT_ALT_W-1:0] OUT_ALTITUDE,
  output logic [IROT_TEMP_W-1:0] OUT_TEMP,
  output logic OUT_VALID
);

  logic [7:0] pin_ctrl_q;
  logic [7:0] irq_enable_q;
  logic [7:0] interrupt_pin_routing_q;
  logic [7:0] pressure_offset_trim_q;
  logic [7:0] temperature_offset_trim_q;
  logic [7:0] altitude_offset_trim_q;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic any_a;
  logic any_b;
  logic pin_a_o_q;
  logic pin_a_oe_q;
  logic pin_b_o_q;
  logic pin_b_oe_q;
  logic [IROT_PRESSURE_W-1:0] p_trimmed;
  logic [IROT_ALT_W-1:0] a_trimmed;
  logic [IROT_TEMP_W-1:0] t_trimmed;
  logic [IROT_PRESSURE_W-1:0] p_out_q;
  logic [IROT_ALT_W-1:0] a_out_q;
  logic [IROT_TEMP_W-1:0] t_out_q;
  logic out_valid_q;

  // Level the pin shows when asserted or idle, per polarity select
  function automatic logic pin_level(input logic asserted, input logic pol);
    pin_level = pol ? asserted : ~asserted;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction

  // Register writes
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pin_ctrl_q <= IROT_RST_PIN_CTRL;
    end else if (REG_WR && hit(REG_ADDR, IROT_ADDR_PIN_CTRL)) begin
      pin_ctrl_q <= REG_WDATA & IROT_PIN_CTRL_MASK;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      irq_enable_q <= IROT_RST_IRQ_ENABLE;
    end else if (REG_WR && hit(REG_ADDR, IROT_ADDR_IRQ_ENABLE)) begin
      irq_enable_q <= REG_WDATA;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      interrupt_pin_routing_q <= IROT_RST_PIN_ROUTING;
    end else if (REG_WR && hit(REG_ADDR, IROT_ADDR_PIN_ROUTING)) begin
      interrupt_pin_routing_q <= REG_WDATA;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pressure_offset_trim_q <= IROT_RST_TRIM;
    end else if (REG_WR && hit(REG_ADDR, IROT_ADDR_PRESSURE_TRIM)) begin
      pressure_offset_trim_q <= REG_WDATA;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      temperature_offset_trim_q <= IROT_RST_TRIM;
    end else if (REG_WR && hit(REG_ADDR, IROT_ADDR_TEMP_TRIM)) begin
      temperature_offset_trim_q <= REG_WDATA;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      altitude_offset_trim_q <= IROT_RST_TRIM;
    end else if (REG_WR && hit(REG_ADDR, IROT_ADDR_ALT_TRIM)) begin
      altitude_offset_trim_q <= REG_WDATA;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (REG_ADDR)
      IROT_ADDR_PIN_CTRL: rdata_d = pin_ctrl_q;
      IROT_ADDR_IRQ_ENABLE: rdata_d = irq_enable_q;
      IROT_ADDR_PIN_ROUTING: rdata_d = interrupt_pin_routing_q;
      IROT_ADDR_PRESSURE_TRIM: rdata_d = pressure_offset_trim_q;
      IROT_ADDR_TEMP_TRIM: rdata_d = temperature_offset_trim_q;
      IROT_ADDR_ALT_TRIM: rdata_d = altitude_offset_trim_q;
      default: rdata_d = IROT_RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rdata_q <= IROT_RD_UNMAPPED;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= REG_RD;
      if (REG_RD) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // Interrupt routing
  irot_route u_route (
    .src(SRC_EVENT),
    .enable(irq_enable_q),
    .route(interrupt_pin_routing_q),
    .any_a(any_a),
    .any_b(any_b)
  );

  // Pin drivers: push-pull drives both levels, open-drain only pulls low
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pin_a_o_q <= 1'b1;
      pin_a_oe_q <= 1'b1;
    end else if (pin_ctrl_q[IROT_BIT_PIN_A_OD]) begin
      pin_a_o_q <= 1'b0;
      pin_a_oe_q <= ~pin_level(any_a, pin_ctrl_q[IROT_BIT_PIN_A_POL]);
    end else begin
      pin_a_o_q <= pin_level(any_a, pin_ctrl_q[IROT_BIT_PIN_A_POL]);
      pin_a_oe_q <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pin_b_o_q <= 1'b1;
      pin_b_oe_q <= 1'b1;
    end else if (pin_ctrl_q[IROT_BIT_PIN_B_OD]) begin
      pin_b_o_q <= 1'b0;
      pin_b_oe_q <= ~pin_level(any_b, pin_ctrl_q[IROT_BIT_PIN_B_POL]);
    end else begin
      pin_b_o_q <= pin_level(any_b, pin_ctrl_q[IROT_BIT_PIN_B_POL]);
      pin_b_oe_q <= 1'b1;
    end
  end

  // Offset trims: pressure in quarter pascals, so one count is 16 LSBs
  irot_offset_add #(
    .W(IROT_PRESSURE_W),
    .SH(IROT_PRESSURE_TRIM_SH),
    .SGN(1'b0)
  ) u_p_trim (
    .raw(MEAS_PRESSURE),
    .trim(pressure_offset_trim_q),
    .trimmed(p_trimmed)
  );

  // Temperature in 1/16 degree, one count is one LSB
  irot_offset_add #(
    .W(IROT_TEMP_W),
    .SH(IROT_TEMP_TRIM_SH),
    .SGN(1'b1)
  ) u_t_trim (
    .raw(MEAS_TEMP),
    .trim(temperature_offset_trim_q),
    .trimmed(t_trimmed)
  );

  // Altitude in 1/16 meter, one count is one meter
  irot_offset_add #(
    .W(IROT_ALT_W),
    .SH(IROT_ALT_TRIM_SH),
    .SGN(1'b1)
  ) u_a_trim (
    .raw(MEAS_ALTITUDE),
    .trim(altitude_offset_trim_q),
    .trimmed(a_trimmed)
  );

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      p_out_q <= '0;
      t_out_q <= '0;
      a_out_q <= '0;
      out_valid_q <= 1'b0;
    end else begin
      out_valid_q <= MEAS_VALID;
      if (MEAS_VALID) begin
        p_out_q <= p_trimmed;
        t_out_q <= t_trimmed;
        a_out_q <= a_trimmed;
      end
    end
  end

  always_comb begin
    REG_RDATA = rdata_q;
    REG_RVALID = rvalid_q;
    IRQ_PIN_A_O = pin_a_o_q;
    IRQ_PIN_A_OE = pin_a_oe_q;
    IRQ_PIN_B_O = pin_b_o_q;
    IRQ_PIN_B_OE = pin_b_oe_q;
    OUT_PRESSURE = p_out_q;
    OUT_TEMP = t_out_q;
    OUT_ALTITUDE = a_out_q;
    OUT_VALID = out_valid_q;
  end

endmodule

/* File: irot_pkg.sv */
package irot_pkg;

  // Register map of the serial register port
  localparam logic [7:0] IROT_ADDR_PIN_CTRL = 8'h28;
  localparam logic [7:0] IROT_ADDR_IRQ_ENABLE = 8'h29;
  localparam logic [7:0] IROT_ADDR_PIN_ROUTING = 8'h2A;
  localparam logic [7:0] IROT_ADDR_PRESSURE_TRIM = 8'h2B;
  localparam logic [7:0] IROT_ADDR_TEMP_TRIM = 8'h2C;
  localparam logic [7:0] IROT_ADDR_ALT_TRIM = 8'h2D;

  // Reset values
  localparam logic [7:0] IROT_RST_PIN_CTRL = 8'h00;
  localparam logic [7:0] IROT_RST_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] IROT_RST_PIN_ROUTING = 8'h00;
  localparam logic [7:0] IROT_RST_TRIM = 8'h00;
  localparam logic [7:0] IROT_RD_UNMAPPED = 8'h00;

  // Pin control fields
  localparam int IROT_BIT_PIN_A_POL = 5;
  localparam int IROT_BIT_PIN_A_OD = 4;
  localparam int IROT_BIT_PIN_B_POL = 1;
  localparam int IROT_BIT_PIN_B_OD = 0;
  localparam logic [7:0] IROT_PIN_CTRL_MASK = 8'h33;

  // Source bit positions in enable and routing registers
  localparam int IROT_SRC_DATA_READY = 7;
  localparam int IROT_SRC_FIFO = 6;
  localparam int IROT_SRC_PRESSURE_WINDOW = 5;
  localparam int IROT_SRC_TEMP_WINDOW = 4;
  localparam int IROT_SRC_PRESSURE_THRESHOLD = 3;
  localparam int IROT_SRC_TEMP_THRESHOLD = 2;
  localparam int IROT_SRC_PRESSURE_CHANGE = 1;
  localparam int IROT_SRC_TEMP_CHANGE = 0;
  localparam int IROT_NUM_SRC = 8;

  // Measurement widths and trim scaling (left shift of the trim count)
  localparam int IROT_PRESSURE_W = 20;
  localparam int IROT_ALT_W = 20;
  localparam int IROT_TEMP_W = 12;
  localparam int IROT_PRESSURE_TRIM_SH = 4;
  localparam int IROT_TEMP_TRIM_SH = 0;
  localparam int IROT_ALT_TRIM_SH = 4;

endpackage

/* File: irot_route.sv */
`timescale 1ns/1ps
module irot_route
  import irot_pkg::*;
(
  input wire logic [IROT_NUM_SRC-1:0] src,
  input wire logic [IROT_NUM_SRC-1:0] enable,
  input wire logic [IROT_NUM_SRC-1:0] route,
  output logic any_a,
  output logic any_b
);

  logic [IROT_NUM_SRC-1:0] live;

  always_comb begin
    live = src & enable;
    any_a = |(live & route);
    any_b = |(live & ~route);
  end

endmodule

/* File: irot_offset_add.sv */
`timescale 1ns/1ps
module irot_offset_add #(
  parameter int W = 20,
  parameter int SH = 0,
  parameter bit SGN = 1'b1
) (
  input wire logic [W-1:0] raw,
  input wire logic [7:0] trim,
  output logic [W-1:0] trimmed
);

  localparam int SW = W + 2;

  logic signed [SW-1:0] raw_x;
  logic signed [SW-1:0] trim_x;
  logic signed [SW-1:0] sum;
  logic signed [SW-1:0] max_v;
  logic signed [SW-1:0] min_v;

  always_comb begin
    if (SGN) begin
      raw_x = $signed({{2{raw[W-1]}}, raw});
      max_v = $signed({3'b000, {(W-1){1'b1}}});
      min_v = $signed({3'b111, {(W-1){1'b0}}});
    end else begin
      raw_x = $signed({2'b00, raw});
      max_v = $signed({2'b00, {W{1'b1}}});
      min_v = '0;
    end
    // Trim is two's complement, sign-extended then scaled
    trim_x = $signed({{(SW-8){trim[7]}}, trim}) <<< SH;
    sum = raw_x + trim_x;
    // Clamp instead of wrapping so a trim never flips the result's range
    if (sum > max_v) begin
      trimmed = max_v[W-1:0];
    end else if (sum < min_v) begin
      trimmed = min_v[W-1:0];
    end else begin
      trimmed = sum[W-1:0];
    end
  end

endmodule

/* File: irot_checker_assertions.sv */
`timescale 1ns/1ps
module irot_checker
  import irot_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_RVALID,
  input wire logic [7:0] SRC_EVENT,
  input wire logic IRQ_PIN_A_O,
  input wire logic IRQ_PIN_A_OE,
  input wire logic IRQ_PIN_B_O,
  input wire logic IRQ_PIN_B_OE,
  input wire logic MEAS_VALID,
  input wire logic [19:0] OUT_PRESSURE,
  input wire logic OUT_VALID
);
  logic [7:0] ctl_q;
  logic [7:0] en_q;
  logic [7:0] rt_q;
  logic lva_q;
  logic lvb_q;
  logic oda_q;
  logic odb_q;
  // Shadow of the pin setup registers, written like the device except pin control is stored unmasked
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ctl_q <= 8'h00;
      en_q <= 8'h00;
      rt_q <= 8'h00;
    end else if (REG_WR) begin
      if (REG_ADDR == IROT_ADDR_PIN_CTRL) ctl_q <= REG_WDATA;
      if (REG_ADDR == IROT_ADDR_IRQ_ENABLE) en_q <= REG_WDATA;
      if (REG_ADDR == IROT_ADDR_PIN_ROUTING) rt_q <= REG_WDATA;
    end
  end
  // Expected pin levels one cycle after sources and setup
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      lva_q <= 1'b1;
      lvb_q <= 1'b1;
      oda_q <= 1'b0;
      odb_q <= 1'b0;
    end else begin
      lva_q <= ~((|(SRC_EVENT & en_q & rt_q)) ^ ctl_q[5]);
      lvb_q <= ~((|(SRC_EVENT & en_q & ~rt_q)) ^ ctl_q[1]);
      // Drive mode as the pin flops saw it, aligned with the levels
      oda_q <= ctl_q[4];
      odb_q <= ctl_q[0];
    end
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  a_rd_answer: assert property (REG_RD |=> REG_RVALID)
    else $error("read got no valid");
  a_rvalid_cause: assert property (REG_RVALID |-> $past(REG_RD))
    else $error("valid without read");
  a_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data moved");
  a_pin_a_level: assert property (!oda_q |->
    IRQ_PIN_A_O == lva_q && IRQ_PIN_A_OE) else $error("pin A wrong");
  a_pin_b_level: assert property (!odb_q |->
    IRQ_PIN_B_O == lvb_q && IRQ_PIN_B_OE) else $error("pin B wrong");
  a_pin_a_drain: assert property (oda_q |->
    !IRQ_PIN_A_O && IRQ_PIN_A_OE == !lva_q) else $error("pin A drain");
  a_pin_b_drain: assert property (odb_q |->
    !IRQ_PIN_B_O && IRQ_PIN_B_OE == !lvb_q) else $error("pin B drain");
  a_disabled_quiet: assert property ((SRC_EVENT & en_q) == 8'h00 &&
    ctl_q == 8'h00 |=> IRQ_PIN_A_O && IRQ_PIN_B_O)
    else $error("disabled source on pin");
  a_out_follow: assert property (MEAS_VALID |=> OUT_VALID)
    else $error("result not issued");
  a_out_cause: assert property (OUT_VALID |-> $past(MEAS_VALID))
    else $error("result without input");
  a_out_hold: assert property (!MEAS_VALID |=> $stable(OUT_PRESSURE))
    else $error("result moved");
  c_read: cover property (REG_RVALID);
  c_both: cover property (!IRQ_PIN_A_O && !IRQ_PIN_B_O);
  c_meas: cover property (OUT_VALID);
endmodule
bind irot_top irot_checker u_chk (.REF_CLK, .RST, .REG_ADDR, .REG_WR,
  .REG_WDATA, .REG_RD, .REG_RDATA, .REG_RVALID, .SRC_EVENT, .IRQ_PIN_A_O,
  .IRQ_PIN_A_OE, .IRQ_PIN_B_O, .IRQ_PIN_B_OE, .MEAS_VALID, .OUT_PRESSURE,
  .OUT_VALID);

/* File: irot_host.sv */
`timescale 1ns/1ps
module irot_host (
  input wire logic clk,
  output logic [7:0] addr,
  output logic wr,
  output logic [7:0] wd,
  output logic rd,
  input wire logic [7:0] rdat,
  input wire logic rv
);
  initial begin
    addr = 8'h00;
    wr = 1'b0;
    wd = 8'h00;
    rd = 1'b0;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wd <= ~d;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d,
                        output logic ok);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    ok = rv;
    d = rdat;
  endtask
endmodule

/* File: test_irot_top.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module test_irot_top import irot_pkg::*;;
  logic clk, rst, wr, rd, mv, rv, ao, aoe, bo, boe, ov;
  logic [7:0] addr, wd, rdat, src;
  logic [19:0] mp, ma, op, oa;
  logic [11:0] mt, ot;
  int error_cnt, tests_run, cyc;
  irot_top DUT (.REF_CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WR(wr),
    .REG_WDATA(wd), .REG_RD(rd), .REG_RDATA(rdat), .REG_RVALID(rv),
    .SRC_EVENT(src), .IRQ_PIN_A_O(ao), .IRQ_PIN_A_OE(aoe),
    .IRQ_PIN_B_O(bo), .IRQ_PIN_B_OE(boe), .MEAS_VALID(mv),
    .MEAS_PRESSURE(mp), .MEAS_ALTITUDE(ma), .MEAS_TEMP(mt),
    .OUT_PRESSURE(op), .OUT_ALTITUDE(oa), .OUT_TEMP(ot), .OUT_VALID(ov));
  irot_host host (.clk, .addr, .wr, .wd, .rd, .rdat, .rv);
  task automatic wrap_up;
    if (error_cnt == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    host.rd_reg(a, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d, e)
  endtask
  task automatic pins(input logic [7:0] s, input logic ea, input logic eb);
    @(posedge clk);
    src <= s;
    repeat (2) @(posedge clk);
    // Look after the edge has settled the pin flops
    #1;
    `CHK(ao, ea)
    `CHK(bo, eb)
  endtask
  task automatic t_regs;
    rdchk(IROT_ADDR_PIN_ROUTING, 8'h00);
    rdchk(IROT_ADDR_PRESSURE_TRIM, 8'h00);
    rdchk(IROT_ADDR_TEMP_TRIM, 8'h00);
    rdchk(IROT_ADDR_ALT_TRIM, 8'h00);
    for (int i = 0; i < 4; i++)
      host.wr_reg(IROT_ADDR_PIN_ROUTING + 8'(i), 8'hA5 ^ 8'(i));
    for (int i = 0; i < 4; i++)
      rdchk(IROT_ADDR_PIN_ROUTING + 8'(i), 8'hA5 ^ 8'(i));
    host.wr_reg(8'h40, 8'hFF);
    rdchk(8'h40, IROT_RD_UNMAPPED);
  endtask
  task automatic t_route;
    host.wr_reg(IROT_ADDR_IRQ_ENABLE, 8'hFF);
    host.wr_reg(IROT_ADDR_PIN_ROUTING, 8'hF0);
    for (int i = 0; i < 8; i++)
      pins(8'h01 << i, i < 4, i >= 4);
    pins(8'h81, 1'b0, 1'b0);
    pins(8'h80, 1'b0, 1'b1);
    rdchk(IROT_ADDR_PIN_ROUTING, 8'hF0);
    host.wr_reg(IROT_ADDR_IRQ_ENABLE, 8'h0F);
    pins(8'hF0, 1'b1, 1'b1);
    pins(8'h01, 1'b1, 1'b0);
    host.wr_reg(IROT_ADDR_PIN_CTRL, 8'h22);
    pins(8'h00, 1'b0, 1'b0);
    pins(8'h01, 1'b0, 1'b1);
    // Open-drain, active low: only an asserted pin is driven
    host.wr_reg(IROT_ADDR_PIN_CTRL, 8'h11);
    pins(8'h01, 1'b0, 1'b0);
    `CHK({aoe, boe}, 2'h1)
    pins(8'h00, 1'b0, 1'b0);
    `CHK({aoe, boe}, 2'h0)
  endtask
  task automatic t_meas;
    host.wr_reg(IROT_ADDR_PRESSURE_TRIM, 8'h80);
    host.wr_reg(IROT_ADDR_TEMP_TRIM, 8'hF0);
    host.wr_reg(IROT_ADDR_ALT_TRIM, 8'h7F);
    @(posedge clk);
    mv <= 1'b1;
    mp <= 20'h0_1000;
    ma <= 20'h0_0010;
    mt <= 12'h100;
    @(posedge clk);
    mv <= 1'b0;
    #1;
    `CHK(ov, 1'b1)
    `CHK(op, 20'h0_0800)
    `CHK(ot, 12'h0F0)
    `CHK(oa, 20'h0_0800)
  endtask
  task automatic t_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK(ov, 1'b0)
    `CHK(op, 20'h0_0000)
    `CHK({ao, aoe, bo, boe}, 4'hF)
    rdchk(IROT_ADDR_PIN_ROUTING, 8'h00);
    rdchk(IROT_ADDR_PRESSURE_TRIM, 8'h00);
    rdchk(IROT_ADDR_TEMP_TRIM, 8'h00);
    rdchk(IROT_ADDR_ALT_TRIM, 8'h00);
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    rst = 1'b1;
    src = 8'h00;
    mv = 1'b0;
    mp = 20'h0_0000;
    ma = 20'h0_0000;
    mt = 12'h000;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    pins(8'h00, 1'b1, 1'b1);
    t_regs();
    t_route();
    t_meas();
    t_reset();
    wrap_up();
  end
endmodule
